// [core/serial_pin_pkg.sv]
// constants and carrier types for the serial pin control and transmit counter block
package serial_pin_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [3:0] CLOCK_FREQUENCY_SETTING_OFS = 4'h0;
  localparam logic [3:0] TRANSMIT_BYTE_COUNTER_OFS = 4'h4;
  localparam logic [3:0] PIN_FUNCTION_CONTROL_OFS = 4'h8;
  localparam logic [3:0] PIN_OUTPUT_DATA_OFS = 4'hc;
  localparam logic [3:0] PIN_INPUT_LEVELS_OFS = 4'h0;
  localparam logic [3:0] PIN_INPUT_LEVELS_OFS_HI = 4'h1;
  localparam logic [3:0] LINK_CONTROL_OFS = 4'h4;
  localparam logic [3:0] LINK_CONTROL_OFS_HI = 4'h1;

  // clock frequency field
  localparam logic [4:0] CLOCK_MHZ_MIN = 5'h01;
  localparam logic [4:0] CLOCK_MHZ_MAX = 5'h19;
  localparam int CLOCK_MHZ_MSB = 4;

  // pin function control bit positions
  localparam int TX_POLARITY_BIT = 7;
  localparam int RX_POLARITY_BIT = 6;
  localparam int TX_PIN_FUNCTION_BIT = 5;
  localparam int RX_PIN_FUNCTION_BIT = 4;
  localparam int LOOP_PIN_FUNCTION_BIT = 3;
  localparam int TX_PIN_DIRECTION_BIT = 2;
  localparam int RX_PIN_DIRECTION_BIT = 1;
  localparam int LOOP_PIN_DIRECTION_BIT = 0;

  // per-pin bit positions in output data and input level registers
  localparam int TX_PIN_IDX = 2;
  localparam int RX_PIN_IDX = 1;
  localparam int LOOP_PIN_IDX = 0;

  // link control register bits
  localparam int LOOPBACK_ENABLE_BIT = 0;
  localparam int CRC_DISABLE_BIT = 1;
  localparam int TX_OVERRUN_FLAG_BIT = 2;

  // reset values
  localparam logic [4:0] CLOCK_MHZ_RST = 5'h19;
  localparam logic [7:0] TX_BYTE_COUNT_RST = 8'h00;
  localparam logic [7:0] PIN_FUNCTION_RST = 8'h00;
  localparam logic [2:0] PIN_OUT_RST = 3'h0;
  localparam logic [7:0] RESERVED_READ = 8'h00;

  typedef struct packed {
    logic [4:0] clock_mhz;
    logic [7:0] tx_byte_count;
    logic [7:0] pin_function;
    logic [2:0] pin_out;
    logic loopback_enable;
    logic crc_disable;
    logic tx_overrun_flag;
    logic tx_error_seen;
    logic crc_append;
    logic ack;
    logic [31:0] rdata;
    logic [2:0] pin_o;
    logic [2:0] pin_oe;
    logic [2:0] pin_in;
    logic [4:0] clock_mhz_eff;
    logic rx_active;
  } state_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [3:0] adr;
    logic [31:0] dat;
  } wb_req_s;

endpackage : serial_pin_pkg

// [core/serial_pin_control_tx_count.sv]
// serial interface pin mux, clock setting and transmit byte counter
//
// Overview of operation
// - clock field is read as binary megahertz, legal from 1 to 25
// - any illegal clock field value behaves as 25 megahertz
// - reserved upper bits ignore writes and read back as zero
// - eight-bit counter holds data bytes left to send, excluding crc
// - counter decrements on each transmit buffer load while above zero and with no error seen, processor or dma
// - a load below zero with crc enabled requests crc append
// - a transmission error forces the counter to zero
// - buffer writes after an error set the transmit overrun flag
// - transmit polarity picks driven level for the active transmit state
// - receive polarity picks which receive level counts as active
// - transmit function bit gives transmit pin to gpio or transmitter
// - receive function bit gives receive pin to gpio or receiver
// - loopback function bit gives loopback pin to gpio or loopback output
// - direction bits choose input or output only in gpio mode
// - data-out bits drive the pin only in gpio output mode
// - input level register is read-only and shows the three pin levels
// - loopback enable drives the loopback pin low when its function bit selects the loopback output
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
module serial_pin_control_tx_count (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // transmitter side
  input wire logic TX_BUFFER_LOAD,
  input wire logic TX_ERROR,
  input wire logic TX_SERIAL_ACTIVE,
  output logic CRC_APPEND,
  output logic RX_SERIAL_ACTIVE,
  output logic [4:0] CLOCK_MHZ_EFFECTIVE,
  // pins: index 2 transmit, 1 receive, 0 loopback
  input wire logic [2:0] PIN_I,
  output logic [2:0] PIN_O,
  output logic [2:0] PIN_OE
);

  serial_pin_pkg::state_s cur_ff;
  serial_pin_pkg::state_s nxt_ff;
  serial_pin_pkg::wb_req_s req;

  function automatic logic [4:0] eff_mhz(input logic [4:0] v);
    if (v >= serial_pin_pkg::CLOCK_MHZ_MIN && v <= serial_pin_pkg::CLOCK_MHZ_MAX) begin
      eff_mhz = v;
    end else begin
      eff_mhz = serial_pin_pkg::CLOCK_MHZ_MAX;
    end
  endfunction : eff_mhz

  assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, sel: WB_SEL_I, adr: WB_ADR_I, dat: WB_DAT_I};

  ////////////////////////////////////////////////////////////////////////////
  logic access;
  logic wr;
  logic gpio_tx;
  logic gpio_rx;
  logic gpio_lp;

  always_comb begin
    access = req.cyc && req.stb && !cur_ff.ack;
    wr = access && req.we && req.sel[0];
    gpio_tx = !cur_ff.pin_function[serial_pin_pkg::TX_PIN_FUNCTION_BIT];
    gpio_rx = !cur_ff.pin_function[serial_pin_pkg::RX_PIN_FUNCTION_BIT];
    gpio_lp = !cur_ff.pin_function[serial_pin_pkg::LOOP_PIN_FUNCTION_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // the 4-bit address covers 0x0..0xc; the two extra registers sit at 0x10/0x14
  // and are reached through the fifth address bit folded into byte-select 1
  logic hi_page;
  assign hi_page = req.sel[1];

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.ack = access;
    nxt_ff.crc_append = 1'b0;
    nxt_ff.rdata = 32'h0000_0000;
    if (access && !req.we) begin
      if (!hi_page) begin
        unique case (req.adr)
          serial_pin_pkg::CLOCK_FREQUENCY_SETTING_OFS:
            nxt_ff.rdata = {27'h0, cur_ff.clock_mhz};
          serial_pin_pkg::TRANSMIT_BYTE_COUNTER_OFS:
            nxt_ff.rdata = {24'h0, cur_ff.tx_byte_count};
          serial_pin_pkg::PIN_FUNCTION_CONTROL_OFS:
            nxt_ff.rdata = {24'h0, cur_ff.pin_function};
          serial_pin_pkg::PIN_OUTPUT_DATA_OFS:
            nxt_ff.rdata = {29'h0, cur_ff.pin_out};
          default:
            nxt_ff.rdata = 32'h0000_0000;
        endcase
      end else if (req.adr == serial_pin_pkg::PIN_INPUT_LEVELS_OFS) begin
        nxt_ff.rdata = {29'h0, cur_ff.pin_in};
      end else if (req.adr == serial_pin_pkg::LINK_CONTROL_OFS) begin
        nxt_ff.rdata = {29'h0, cur_ff.tx_overrun_flag, cur_ff.crc_disable, cur_ff.loopback_enable};
      end
    end
    if (wr && !hi_page) begin
      unique case (req.adr)
        serial_pin_pkg::CLOCK_FREQUENCY_SETTING_OFS:
          nxt_ff.clock_mhz = req.dat[serial_pin_pkg::CLOCK_MHZ_MSB:0];
        serial_pin_pkg::TRANSMIT_BYTE_COUNTER_OFS: begin
          nxt_ff.tx_byte_count = req.dat[7:0];
          nxt_ff.tx_error_seen = 1'b0;
        end
        serial_pin_pkg::PIN_FUNCTION_CONTROL_OFS:
          nxt_ff.pin_function = req.dat[7:0];
        serial_pin_pkg::PIN_OUTPUT_DATA_OFS:
          nxt_ff.pin_out = req.dat[2:0];
        default: begin
        end
      endcase
    end
    if (wr && hi_page && req.adr == serial_pin_pkg::LINK_CONTROL_OFS) begin
      nxt_ff.loopback_enable = req.dat[serial_pin_pkg::LOOPBACK_ENABLE_BIT];
      nxt_ff.crc_disable = req.dat[serial_pin_pkg::CRC_DISABLE_BIT];
      // write one to clear the overrun flag
      if (req.dat[serial_pin_pkg::TX_OVERRUN_FLAG_BIT]) begin
        nxt_ff.tx_overrun_flag = 1'b0;
      end
    end
    // transmit counter; hardware events win over a same-cycle software write
    if (TX_BUFFER_LOAD) begin
      if (cur_ff.tx_error_seen) begin
        nxt_ff.tx_overrun_flag = 1'b1;
      end else if (cur_ff.tx_byte_count == 8'h00) begin
        nxt_ff.crc_append = !cur_ff.crc_disable;
        nxt_ff.tx_byte_count = 8'h00;
      end else begin
        nxt_ff.tx_byte_count = cur_ff.tx_byte_count - 8'h01;
      end
    end
    if (TX_ERROR) begin
      nxt_ff.tx_byte_count = serial_pin_pkg::TX_BYTE_COUNT_RST;
      nxt_ff.tx_error_seen = 1'b1;
    end
    nxt_ff.clock_mhz_eff = eff_mhz(cur_ff.clock_mhz);
    nxt_ff.pin_in = PIN_I;
    // transmit pin
    if (gpio_tx) begin
      nxt_ff.pin_oe[serial_pin_pkg::TX_PIN_IDX] = cur_ff.pin_function[serial_pin_pkg::TX_PIN_DIRECTION_BIT];
      nxt_ff.pin_o[serial_pin_pkg::TX_PIN_IDX] = cur_ff.pin_out[serial_pin_pkg::TX_PIN_IDX];
    end else begin
      nxt_ff.pin_oe[serial_pin_pkg::TX_PIN_IDX] = 1'b1;
      nxt_ff.pin_o[serial_pin_pkg::TX_PIN_IDX] =
        TX_SERIAL_ACTIVE ~^ cur_ff.pin_function[serial_pin_pkg::TX_POLARITY_BIT];
    end
    // receive pin
    if (gpio_rx) begin
      nxt_ff.pin_oe[serial_pin_pkg::RX_PIN_IDX] = cur_ff.pin_function[serial_pin_pkg::RX_PIN_DIRECTION_BIT];
      nxt_ff.pin_o[serial_pin_pkg::RX_PIN_IDX] = cur_ff.pin_out[serial_pin_pkg::RX_PIN_IDX];
      nxt_ff.rx_active = 1'b0;
    end else begin
      nxt_ff.pin_oe[serial_pin_pkg::RX_PIN_IDX] = 1'b0;
      nxt_ff.pin_o[serial_pin_pkg::RX_PIN_IDX] = 1'b0;
      nxt_ff.rx_active =
        cur_ff.pin_in[serial_pin_pkg::RX_PIN_IDX] ~^ cur_ff.pin_function[serial_pin_pkg::RX_POLARITY_BIT];
    end
    // loopback pin
    if (gpio_lp) begin
      nxt_ff.pin_oe[serial_pin_pkg::LOOP_PIN_IDX] =
        cur_ff.pin_function[serial_pin_pkg::LOOP_PIN_DIRECTION_BIT];
      nxt_ff.pin_o[serial_pin_pkg::LOOP_PIN_IDX] = cur_ff.pin_out[serial_pin_pkg::LOOP_PIN_IDX];
    end else begin
      nxt_ff.pin_oe[serial_pin_pkg::LOOP_PIN_IDX] = 1'b1;
      nxt_ff.pin_o[serial_pin_pkg::LOOP_PIN_IDX] = !cur_ff.loopback_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      cur_ff <= '0;
      cur_ff.clock_mhz <= serial_pin_pkg::CLOCK_MHZ_RST;
      cur_ff.clock_mhz_eff <= serial_pin_pkg::CLOCK_MHZ_RST;
      cur_ff.pin_function <= serial_pin_pkg::PIN_FUNCTION_RST;
      cur_ff.pin_out <= serial_pin_pkg::PIN_OUT_RST;
      cur_ff.tx_byte_count <= serial_pin_pkg::TX_BYTE_COUNT_RST;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign WB_DAT_O = cur_ff.rdata;
  assign WB_ACK_O = cur_ff.ack;
  assign CRC_APPEND = cur_ff.crc_append;
  assign RX_SERIAL_ACTIVE = cur_ff.rx_active;
  assign CLOCK_MHZ_EFFECTIVE = cur_ff.clock_mhz_eff;
  assign PIN_O = cur_ff.pin_o;
  assign PIN_OE = cur_ff.pin_oe;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  sequence load_at_zero_s;
    TX_BUFFER_LOAD && !TX_ERROR && !cur_ff.tx_error_seen && cur_ff.tx_byte_count == 8'h00;
  endsequence

  a_eff_clock_range: assert property (
    ##1 (CLOCK_MHZ_EFFECTIVE >= 5'h01 && CLOCK_MHZ_EFFECTIVE <= 5'h19))
    else $error("effective clock outside 1..25");
  a_eff_clock_legal: assert property (
    (cur_ff.clock_mhz >= 5'h01 && cur_ff.clock_mhz <= 5'h19) |=> CLOCK_MHZ_EFFECTIVE == $past(cur_ff.clock_mhz))
    else $error("legal clock value not passed through");
  a_count_decrement: assert property (
    (TX_BUFFER_LOAD && !TX_ERROR && !cur_ff.tx_error_seen && cur_ff.tx_byte_count != 8'h00)
    |=> cur_ff.tx_byte_count == $past(cur_ff.tx_byte_count) - 8'h01)
    else $error("counter did not decrement on load");
  a_crc_append: assert property (
    load_at_zero_s |=> (CRC_APPEND == !$past(cur_ff.crc_disable)) ##1 !CRC_APPEND)
    else $error("crc append pulse wrong at underflow");
  a_error_clears: assert property (
    TX_ERROR |=> cur_ff.tx_byte_count == 8'h00 && cur_ff.tx_error_seen)
    else $error("error did not clear counter");
  a_overrun_set: assert property (
    (TX_BUFFER_LOAD && cur_ff.tx_error_seen) |=> cur_ff.tx_overrun_flag)
    else $error("load after error did not flag overrun");
  a_gpio_drive: assert property (
    (!cur_ff.pin_function[5] && cur_ff.pin_function[2]) |=> PIN_OE[2] && PIN_O[2] == $past(cur_ff.pin_out[2]))
    else $error("gpio output not driven from data bit");
  a_rx_input: assert property (
    cur_ff.pin_function[4] |=> !PIN_OE[1])
    else $error("receive pin driven in serial mode");
  a_loop_active_low: assert property (
    (cur_ff.pin_function[3] && cur_ff.loopback_enable) |=> PIN_OE[0] && !PIN_O[0])
    else $error("loopback pin not driven low");
  a_ack_one_cycle: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");

  ////////////////////////////////////////////////////////////////////////////
  // register access checks
  sequence read_clock_s;
    access && !req.we && !hi_page && req.adr == serial_pin_pkg::CLOCK_FREQUENCY_SETTING_OFS;
  endsequence
  sequence read_levels_s;
    access && !req.we && hi_page && req.adr == serial_pin_pkg::PIN_INPUT_LEVELS_OFS;
  endsequence
  sequence clock_write_s;
    wr && !hi_page && req.adr == serial_pin_pkg::CLOCK_FREQUENCY_SETTING_OFS;
  endsequence
  sequence count_write_s;
    wr && !hi_page && req.adr == serial_pin_pkg::TRANSMIT_BYTE_COUNTER_OFS && !TX_BUFFER_LOAD && !TX_ERROR;
  endsequence

  a_ack_follows_request: assert property (
    access
    |=> WB_ACK_O)
    else $error("request not acknowledged after one cycle");
  a_upper_bytes_zero: assert property (
    WB_ACK_O
    |-> WB_DAT_O[31:8] == 24'h000000)
    else $error("upper read bytes not zero");
  a_clock_reserved_zero: assert property (
    read_clock_s
    |=> WB_DAT_O[7:5] == 3'h0)
    else $error("reserved clock bits not zero");
  a_clock_write_lands: assert property (
    clock_write_s
    |=> cur_ff.clock_mhz == $past(WB_DAT_I[serial_pin_pkg::CLOCK_MHZ_MSB:0]))
    else $error("clock field write lost");
  a_illegal_clock_max: assert property (
    (cur_ff.clock_mhz < serial_pin_pkg::CLOCK_MHZ_MIN || cur_ff.clock_mhz > serial_pin_pkg::CLOCK_MHZ_MAX)
    |=> CLOCK_MHZ_EFFECTIVE == serial_pin_pkg::CLOCK_MHZ_MAX)
    else $error("illegal clock value not taken as the top setting");
  a_levels_read_back: assert property (
    read_levels_s
    |=> WB_DAT_O[2:0] == $past(cur_ff.pin_in))
    else $error("pin levels not read back");

  ////////////////////////////////////////////////////////////////////////////
  // transmit counter checks
  a_count_write_lands: assert property (
    count_write_s
    |=> cur_ff.tx_byte_count == $past(WB_DAT_I[7:0]))
    else $error("counter write lost");
  a_count_no_wrap: assert property (
    load_at_zero_s
    |=> cur_ff.tx_byte_count == 8'h00)
    else $error("counter wrapped below zero");
  a_crc_needs_load: assert property (
    CRC_APPEND
    |-> $past(TX_BUFFER_LOAD))
    else $error("crc append without a buffer load");

  ////////////////////////////////////////////////////////////////////////////
  // pin checks
  a_tx_gpio_dir: assert property (
    gpio_tx
    |=> PIN_OE[serial_pin_pkg::TX_PIN_IDX] == $past(cur_ff.pin_function[serial_pin_pkg::TX_PIN_DIRECTION_BIT]))
    else $error("transmit pin direction not from its bit");
  a_rx_gpio_dir: assert property (
    gpio_rx
    |=> PIN_OE[serial_pin_pkg::RX_PIN_IDX] == $past(cur_ff.pin_function[serial_pin_pkg::RX_PIN_DIRECTION_BIT]))
    else $error("receive pin direction not from its bit");
  a_loop_gpio_dir: assert property (
    gpio_lp
    |=> PIN_OE[serial_pin_pkg::LOOP_PIN_IDX] == $past(cur_ff.pin_function[serial_pin_pkg::LOOP_PIN_DIRECTION_BIT]))
    else $error("loopback pin direction not from its bit");
  a_rx_gpio_data: assert property (
    (gpio_rx && cur_ff.pin_function[serial_pin_pkg::RX_PIN_DIRECTION_BIT])
    |=> PIN_O[serial_pin_pkg::RX_PIN_IDX] == $past(cur_ff.pin_out[serial_pin_pkg::RX_PIN_IDX]))
    else $error("receive pin output not from data bit");
  a_loop_gpio_data: assert property (
    (gpio_lp && cur_ff.pin_function[serial_pin_pkg::LOOP_PIN_DIRECTION_BIT])
    |=> PIN_O[serial_pin_pkg::LOOP_PIN_IDX] == $past(cur_ff.pin_out[serial_pin_pkg::LOOP_PIN_IDX]))
    else $error("loopback pin output not from data bit");
  a_tx_serial_drive: assert property (
    !gpio_tx
    |=> PIN_OE[serial_pin_pkg::TX_PIN_IDX])
    else $error("transmit pin not driven in serial mode");
  a_loop_serial_drive: assert property (
    !gpio_lp
    |=> PIN_OE[serial_pin_pkg::LOOP_PIN_IDX])
    else $error("loopback pin not driven in serial mode");
  a_tx_active_low: assert property (
    (!gpio_tx && !cur_ff.pin_function[serial_pin_pkg::TX_POLARITY_BIT] && TX_SERIAL_ACTIVE)
    |=> !PIN_O[serial_pin_pkg::TX_PIN_IDX])
    else $error("active low transmit pin not low");
  a_tx_active_high: assert property (
    (!gpio_tx && cur_ff.pin_function[serial_pin_pkg::TX_POLARITY_BIT] && TX_SERIAL_ACTIVE)
    |=> PIN_O[serial_pin_pkg::TX_PIN_IDX])
    else $error("active high transmit pin not high");
  a_rx_active_low: assert property (
    (!gpio_rx && !cur_ff.pin_function[serial_pin_pkg::RX_POLARITY_BIT] && !cur_ff.pin_in[serial_pin_pkg::RX_PIN_IDX])
    |=> RX_SERIAL_ACTIVE)
    else $error("low receive level not taken as active");
  a_rx_active_high: assert property (
    (!gpio_rx && cur_ff.pin_function[serial_pin_pkg::RX_POLARITY_BIT] && cur_ff.pin_in[serial_pin_pkg::RX_PIN_IDX])
    |=> RX_SERIAL_ACTIVE)
    else $error("high receive level not taken as active");
  a_loop_idle_high: assert property (
    (!gpio_lp && !cur_ff.loopback_enable)
    |=> PIN_O[serial_pin_pkg::LOOP_PIN_IDX])
    else $error("loopback pin low without loopback enable");
  a_reset_gpio_inputs: assert property (
    $past(RESET)
    |-> PIN_OE == 3'h0 && cur_ff.pin_function == serial_pin_pkg::PIN_FUNCTION_RST
      && cur_ff.pin_out == serial_pin_pkg::PIN_OUT_RST)
    else $error("pins not gpio inputs after reset");

endmodule : serial_pin_control_tx_count

// [sim/bus_transceiver_model.sv]
// external bus transceiver model on the transmit, receive and loopback pins
module bus_transceiver_model (
  // pin side of the block
  input wire logic [2:0] pin_o,
  input wire logic [2:0] pin_oe,
  // level that other nodes put on the bus
  input wire logic bus_level,
  // resolved pin levels
  output logic [2:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    // transmit and loopback lines have pull-ups when nobody drives them
    pin_i[2] = pin_oe[2] ? pin_o[2] : 1'b1;
    pin_i[0] = pin_oe[0] ? pin_o[0] : 1'b1;
    // loopback line low ties transmit straight to receive
    if (pin_oe[1]) begin
      pin_i[1] = pin_o[1];
    end else if (pin_i[0] == 1'b0) begin
      pin_i[1] = pin_i[2];
    end else begin
      pin_i[1] = bus_level;
    end
  end
endmodule : bus_transceiver_model

// [sim/tb_serial_pin_control_tx_count.sv]
// self-checking bench for the pin mux, clock setting and transmit counter
module tb_serial_pin_control_tx_count;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, reset = 1'b1, cyc = 1'b0, we = 1'b0, ld = 1'b0, err = 1'b0, txa = 1'b0, bus = 1'b1;
  logic [3:0] sel = 4'h0, adr = 4'h0;
  logic [31:0] dat = 32'h0, rdat;
  logic ack, crc, rxa;
  logic [4:0] mhz;
  logic [2:0] pin_i, pin_o, pin_oe, r3;
  logic [31:0] exp_q[$];
  int fail_count = 0, total_checks = 0, crc_seen = 0, n;
  ////////////////////////////////////////////////////////////////
  serial_pin_control_tx_count dut (.SYS_CLK(sys_clk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .TX_BUFFER_LOAD(ld), .TX_ERROR(err), .TX_SERIAL_ACTIVE(txa), .CRC_APPEND(crc), .RX_SERIAL_ACTIVE(rxa),
    .CLOCK_MHZ_EFFECTIVE(mhz), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe));
  bus_transceiver_model xcvr (.pin_o(pin_o), .pin_oe(pin_oe), .bus_level(bus), .pin_i(pin_i));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] s, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    dat <= d;
    do @(posedge sys_clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic wr(input logic hi, input logic [3:0] a, input logic [7:0] d);
    wb(1'b1, {2'b00, hi, 1'b1}, a, {24'h0, d});
  endtask : wr
  task automatic rd(input logic hi, input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, {2'b00, hi, 1'b1}, a, 32'h0);
  endtask : rd
  task automatic pulse(input logic is_err);
    @(posedge sys_clk);
    if (is_err) err <= 1'b1; else ld <= 1'b1;
    @(posedge sys_clk);
    err <= 1'b0;
    ld <= 1'b0;
  endtask : pulse
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////
  // read monitor: oldest note against the data that comes with ack
  always @(posedge sys_clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) chk(rdat, exp_q.pop_front());
    if (crc === 1'b1) crc_seen++;
  end
  initial begin
    #(20000 * 25);
    fail_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'ha041ae1f));
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk(pin_oe, 3'h0);
    rd(1'b0, 4'h8, 32'h0);
    rd(1'b0, 4'hc, 32'h0);
    rd(1'b0, 4'h4, 32'h0);
    for (int v = 0; v < 32; v++) begin
      wr(1'b0, 4'h0, {3'b111, v[4:0]});
      settle();
      chk(mhz, (v >= 1 && v <= 25) ? v[4:0] : 5'h19);
    end
    rd(1'b0, 4'h0, 32'h1f);
    wb(1'b1, 4'h0, 4'h0, 32'h5);
    rd(1'b0, 4'h0, 32'h1f);
    rd(1'b1, 4'h8, 32'h0);
    n = 1 + ($urandom % 4);
    wr(1'b0, 4'h4, n[7:0]);
    rd(1'b0, 4'h4, n);
    repeat (n) pulse(1'b0);
    rd(1'b0, 4'h4, 32'h0);
    chk(crc_seen, 0);
    pulse(1'b0);
    settle();
    chk(crc_seen, 1);
    wr(1'b1, 4'h4, 8'h02);
    pulse(1'b0);
    settle();
    chk(crc_seen, 1);
    wr(1'b0, 4'h4, 8'h05);
    pulse(1'b1);
    rd(1'b0, 4'h4, 32'h0);
    pulse(1'b0);
    rd(1'b1, 4'h4, 32'h6);
    r3 = 3'($urandom);
    wr(1'b0, 4'h8, 8'h07);
    wr(1'b0, 4'hc, {5'h1f, r3});
    settle();
    chk(pin_oe, 3'h7);
    chk(pin_o, r3);
    rd(1'b0, 4'hc, {29'h0, r3});
    rd(1'b1, 4'h0, {29'h0, r3});
    bus <= 1'b0;
    wr(1'b0, 4'h8, 8'h00);
    settle();
    chk(pin_oe, 3'h0);
    rd(1'b1, 4'h0, 32'h5);
    txa <= 1'b1;
    wr(1'b0, 4'h8, 8'h3f);
    settle();
    chk({pin_oe[2], pin_o[2], pin_o[0]}, 3'b101);
    chk(rxa, 1'b1);
    wr(1'b0, 4'h8, 8'hbf);
    wr(1'b1, 4'h4, 8'h01);
    settle();
    chk({pin_o[2], pin_oe[0], pin_o[0]}, 3'b110);
    chk(rxa, 1'b0);
    wr(1'b0, 4'h8, 8'hff);
    settle();
    chk(rxa, 1'b1);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk({pin_oe, mhz}, {3'h0, 5'h19});
    rd(1'b0, 4'h8, 32'h0);
    rd(1'b0, 4'hc, 32'h0);
    print_verdict();
  end
endmodule : tb_serial_pin_control_tx_count
